// File: logic/fast_counter_pkg.sv
// Package with register map, bit positions and constants of the counter status flags.
package fast_counter_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS_ONE = 8'h00;
  localparam logic [7:0] OFF_STATUS_TWO = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_REFRESH = 8'h0c;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_TARGET = 0;
  localparam int BIT_OVERFLOW = 1;
  localparam int BIT_PHASEZ = 3;
  localparam int BIT_ROT_ERR = 4;
  localparam int BIT_ROT_DONE = 5;
  localparam int BIT_MEASURING = 6;
  localparam int BIT_OPERATING = 7;
  localparam int BIT_LATCHED = 8;
  localparam int BIT_OFFSET_ERR = 12;

  // ----------------------------------------------------------------
  // Control bit positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_START_ONE = 0;
  localparam int CTL_MEAS_ONE = 1;
  localparam int CTL_START_TWO = 2;
  localparam int CTL_MEAS_TWO = 3;
  localparam int CTL_DISPLAY_LSB = 4;
  localparam int CTL_LINEAR_ONE = 6;
  localparam int CTL_LINEAR_TWO = 7;
  localparam int CTL_ZRESET_ONE = 8;
  localparam int CTL_ZRESET_TWO = 9;
  localparam logic [9:0] CONTROL_RESET = 10'h000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] ONE_MASK = 16'h11fb;
  localparam logic [15:0] TWO_MASK = 16'h00fb;

  // ----------------------------------------------------------------
  // Display modes and refresh timing
  // ----------------------------------------------------------------
  localparam logic [1:0] DISPLAY_MOVES = 2'h1;
  localparam logic [1:0] DISPLAY_FREQ = 2'h2;
  localparam logic [15:0] REFRESH_RESET = 16'h00c7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fast_counter_pkg

// File: logic/counter_flag_if.sv
// Interface carrying one counter's raw events and its status word.
`timescale 1ns/1ps
interface counter_flag_if;
  logic start;
  logic measCmd;
  logic linear;
  logic zReset;
  logic displayOk;
  logic freqAllowed;
  logic refresh;
  logic sampleStart;
  logic limitHit;
  logic phaseZDone;
  logic latchDone;
  logic targetBusy;
  logic rotErr;
  logic rotDone;
  logic offsetDone;
  logic offsetFail;
  logic [15:0] status;
  modport top (output start, measCmd, linear, zReset, displayOk, freqAllowed, refresh,
    sampleStart, limitHit, phaseZDone, latchDone, targetBusy, rotErr, rotDone, offsetDone,
    offsetFail, input status);
  modport flags (input start, measCmd, linear, zReset, displayOk, freqAllowed, refresh,
    sampleStart, limitHit, phaseZDone, latchDone, targetBusy, rotErr, rotDone, offsetDone,
    offsetFail, output status);
endinterface : counter_flag_if

// File: logic/counter_flag_unit.sv
// Status word of one counter, updated at each internal refresh.
`timescale 1ns/1ps
module counter_flag_unit
(
  input wire logic clk,
  input wire logic arst_n,
  counter_flag_if.flags io
);

  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic pendMeas_reg;
  logic pendMeas_next;
  logic pendLatch_reg;
  logic pendLatch_next;
  logic pendZ_reg;
  logic pendZ_next;
  logic pendLim_reg;
  logic pendLim_next;
  logic offErr_reg;
  logic offErr_next;

  assign io.status = status_reg;

  always_comb
  begin
    status_next = status_reg;
    pendLatch_next = pendLatch_reg | io.latchDone;
    pendZ_next = pendZ_reg | (io.phaseZDone & io.zReset);
    // A limit pulse between refreshes must survive until the next refresh.
    pendLim_next = pendLim_reg | io.limitHit;
    pendMeas_next = pendMeas_reg;
    offErr_next = offErr_reg;
    if (io.offsetDone)
    begin
      offErr_next = io.offsetFail;
    end
    if (!io.measCmd)
    begin
      pendMeas_next = 1'b0;
    end
    else if (io.sampleStart)
    begin
      pendMeas_next = 1'b1;
    end
    if (io.refresh)
    begin
      status_next = fast_counter_pkg::STATUS_RESET;
      status_next[fast_counter_pkg::BIT_TARGET] = io.targetBusy;
      status_next[fast_counter_pkg::BIT_OVERFLOW] = io.linear & io.start
        & (status_reg[fast_counter_pkg::BIT_OVERFLOW] | pendLim_reg);
      status_next[fast_counter_pkg::BIT_PHASEZ] = pendZ_reg;
      status_next[fast_counter_pkg::BIT_ROT_ERR] = io.rotErr;
      status_next[fast_counter_pkg::BIT_ROT_DONE] = io.rotDone;
      status_next[fast_counter_pkg::BIT_MEASURING] = pendMeas_reg & io.measCmd
        & io.displayOk;
      status_next[fast_counter_pkg::BIT_OPERATING] = io.start;
      status_next[fast_counter_pkg::BIT_LATCHED] = status_reg[fast_counter_pkg::BIT_LATCHED]
        | pendLatch_reg;
      status_next[fast_counter_pkg::BIT_OFFSET_ERR] = offErr_reg;
      pendZ_next = io.phaseZDone & io.zReset;
      pendLatch_next = io.latchDone;
      pendLim_next = io.limitHit;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_reg <= fast_counter_pkg::STATUS_RESET;
      pendMeas_reg <= 1'b0;
      pendLatch_reg <= 1'b0;
      pendZ_reg <= 1'b0;
      pendLim_reg <= 1'b0;
      offErr_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      pendMeas_reg <= pendMeas_next;
      pendLatch_reg <= pendLatch_next;
      pendZ_reg <= pendZ_next;
      pendLim_reg <= pendLim_next;
      offErr_reg <= offErr_next;
    end
  end

endmodule : counter_flag_unit

// File: logic/fast_counter_status_flags.sv
// Status flags of two fast pulse counters with an AXI4-Lite register slave.
// What this block does
// - Measuring flag high while measurement active
// - Mode 1: flag rises at next sampling start
// - Measuring flag meaningful only in display modes 1, 2
// - Operating flag follows counter running state
// - Latched flag set after count capture completes
// - Offset error flag reflects store failure
// - Counter two word mirrors bits 0 to 7
// - Counter two measures change only, no frequency
// - Linear overflow sets flag, cleared by stop
// - Phase Z reset flag pulses one refresh
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fast_counter_status_flags
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] sampleStart,
  input wire logic [1:0] limitHit,
  input wire logic [1:0] phaseZDone,
  input wire logic [1:0] latchDone,
  input wire logic [1:0] targetBusy,
  input wire logic [1:0] rotErr,
  input wire logic [1:0] rotDone,
  input wire logic [1:0] offsetDone,
  input wire logic [1:0] offsetFail,
  output logic [15:0] counterOneStatus,
  output logic [15:0] counterTwoStatus
);

  // ----------------------------------------------------------------
  // Control and refresh state
  // ----------------------------------------------------------------
  logic [9:0] control_reg;
  logic [9:0] control_next;
  logic [15:0] period_reg;
  logic [15:0] period_next;
  logic [15:0] tick_reg;
  logic [15:0] tick_next;
  logic refresh;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic awHeld_reg;
  logic awHeld_next;
  logic wHeld_reg;
  logic wHeld_next;
  logic [7:0] awAddr_reg;
  logic [7:0] awAddr_next;
  logic [31:0] wData_reg;
  logic [31:0] wData_next;
  logic [3:0] wStrb_reg;
  logic [3:0] wStrb_next;
  logic bValid_reg;
  logic bValid_next;
  logic [1:0] bResp_reg;
  logic [1:0] bResp_next;
  logic rValid_reg;
  logic rValid_next;
  logic [31:0] rData_reg;
  logic [31:0] rData_next;
  logic [1:0] rResp_reg;
  logic [1:0] rResp_next;
  logic [15:0] ctlWide;
  logic awReady_reg;
  logic wReady_reg;
  logic arReady_reg;
  logic [15:0] one_reg;
  logic [15:0] two_reg;

  counter_flag_if chOne ();
  counter_flag_if chTwo ();

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == fast_counter_pkg::OFF_STATUS_ONE)
      || (addr == fast_counter_pkg::OFF_STATUS_TWO)
      || (addr == fast_counter_pkg::OFF_CONTROL)
      || (addr == fast_counter_pkg::OFF_REFRESH);
  endfunction : mapped

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
    input logic [3:0] strb);
    merge16 = old;
    if (strb[0])
    begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  assign refresh = (tick_reg == 16'h0000);

  // ----------------------------------------------------------------
  // Per-counter flag units
  // ----------------------------------------------------------------
  logic displayOk;
  assign displayOk = (control_reg[fast_counter_pkg::CTL_DISPLAY_LSB +: 2]
    == fast_counter_pkg::DISPLAY_MOVES)
    || (control_reg[fast_counter_pkg::CTL_DISPLAY_LSB +: 2]
    == fast_counter_pkg::DISPLAY_FREQ);

  assign chOne.start = control_reg[fast_counter_pkg::CTL_START_ONE];
  assign chOne.measCmd = control_reg[fast_counter_pkg::CTL_MEAS_ONE];
  assign chOne.linear = control_reg[fast_counter_pkg::CTL_LINEAR_ONE];
  assign chOne.zReset = control_reg[fast_counter_pkg::CTL_ZRESET_ONE];
  assign chOne.displayOk = displayOk;
  assign chOne.freqAllowed = 1'b1;
  assign chOne.refresh = refresh;
  assign chOne.sampleStart = sampleStart[0];
  assign chOne.limitHit = limitHit[0];
  assign chOne.phaseZDone = phaseZDone[0];
  assign chOne.latchDone = latchDone[0];
  assign chOne.targetBusy = targetBusy[0];
  assign chOne.rotErr = rotErr[0];
  assign chOne.rotDone = rotDone[0];
  assign chOne.offsetDone = offsetDone[0];
  assign chOne.offsetFail = offsetFail[0];

  // Counter two has no frequency mode, so only movement display arms its flag.
  assign chTwo.start = control_reg[fast_counter_pkg::CTL_START_TWO];
  assign chTwo.measCmd = control_reg[fast_counter_pkg::CTL_MEAS_TWO];
  assign chTwo.linear = control_reg[fast_counter_pkg::CTL_LINEAR_TWO];
  assign chTwo.zReset = control_reg[fast_counter_pkg::CTL_ZRESET_TWO];
  assign chTwo.displayOk = (control_reg[fast_counter_pkg::CTL_DISPLAY_LSB +: 2]
    == fast_counter_pkg::DISPLAY_MOVES);
  assign chTwo.freqAllowed = 1'b0;
  assign chTwo.refresh = refresh;
  assign chTwo.sampleStart = sampleStart[1];
  assign chTwo.limitHit = limitHit[1];
  assign chTwo.phaseZDone = phaseZDone[1];
  assign chTwo.latchDone = latchDone[1];
  assign chTwo.targetBusy = targetBusy[1];
  assign chTwo.rotErr = rotErr[1];
  assign chTwo.rotDone = rotDone[1];
  assign chTwo.offsetDone = offsetDone[1];
  assign chTwo.offsetFail = offsetFail[1];

  counter_flag_unit unitOne
  (
    .clk(clk),
    .arst_n(arst_n),
    .io(chOne.flags)
  );

  counter_flag_unit unitTwo
  (
    .clk(clk),
    .arst_n(arst_n),
    .io(chTwo.flags)
  );

  // ----------------------------------------------------------------
  // Refresh tick and bus slave next state
  // ----------------------------------------------------------------
  always_comb
  begin
    tick_next = (tick_reg == 16'h0000) ? period_reg : tick_reg - 16'h0001;
    ctlWide = merge16({6'h00, control_reg}, wData_reg, wStrb_reg);
    control_next = control_reg;
    period_next = period_reg;
    awHeld_next = awHeld_reg;
    wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;
    rValid_next = rValid_reg;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    if (s_axi_awvalid && awReady_reg)
    begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_reg)
    begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (bValid_reg && s_axi_bready)
    begin
      bValid_next = 1'b0;
    end
    if (awHeld_reg && wHeld_reg && !bValid_reg)
    begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = mapped(awAddr_reg) ? fast_counter_pkg::RESP_OKAY
        : fast_counter_pkg::RESP_SLVERR;
      // Status words ignore writes; the flags belong to the hardware.
      if (awAddr_reg == fast_counter_pkg::OFF_CONTROL)
      begin
        control_next = ctlWide[9:0];
      end
      else if (awAddr_reg == fast_counter_pkg::OFF_REFRESH)
      begin
        period_next = merge16(period_reg, wData_reg, wStrb_reg);
      end
    end
    if (rValid_reg && s_axi_rready)
    begin
      rValid_next = 1'b0;
    end
    if (s_axi_arvalid && arReady_reg)
    begin
      rValid_next = 1'b1;
      rResp_next = mapped(s_axi_araddr) ? fast_counter_pkg::RESP_OKAY
        : fast_counter_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        fast_counter_pkg::OFF_STATUS_ONE: rData_next = {16'h0000,
          chOne.status & fast_counter_pkg::ONE_MASK};
        fast_counter_pkg::OFF_STATUS_TWO: rData_next = {16'h0000,
          chTwo.status & fast_counter_pkg::TWO_MASK};
        fast_counter_pkg::OFF_CONTROL: rData_next = {22'h000000, control_reg};
        fast_counter_pkg::OFF_REFRESH: rData_next = {16'h0000, period_reg};
        default: rData_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      control_reg <= fast_counter_pkg::CONTROL_RESET;
      period_reg <= fast_counter_pkg::REFRESH_RESET;
      tick_reg <= fast_counter_pkg::REFRESH_RESET;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= fast_counter_pkg::RESP_OKAY;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h00000000;
      rResp_reg <= fast_counter_pkg::RESP_OKAY;
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
      arReady_reg <= 1'b0;
      one_reg <= fast_counter_pkg::STATUS_RESET;
      two_reg <= fast_counter_pkg::STATUS_RESET;
    end
    else
    begin
      control_reg <= control_next;
      period_reg <= period_next;
      tick_reg <= tick_next;
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      rValid_reg <= rValid_next;
      rData_reg <= rData_next;
      rResp_reg <= rResp_next;
      awReady_reg <= !awHeld_next && !bValid_next;
      wReady_reg <= !wHeld_next && !bValid_next;
      arReady_reg <= !rValid_next;
      one_reg <= chOne.status & fast_counter_pkg::ONE_MASK;
      two_reg <= chTwo.status & fast_counter_pkg::TWO_MASK;
    end
  end

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign counterOneStatus = one_reg;
  assign counterTwoStatus = two_reg;

endmodule : fast_counter_status_flags

// File: verif/status_flags_assertions.sv
// Port checks for the counter status flags block.
`timescale 1ns/1ps
module status_flags_assertions
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [15:0] counterOneStatus,
  input wire logic [15:0] counterTwoStatus
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_one_reserved: assert property (
    (counterOneStatus & ~fast_counter_pkg::ONE_MASK) == 16'h0000)
    else $error("reserved bit set in word one");
  chk_two_mirror: assert property (
    counterTwoStatus[15:8] == 8'h00 && !counterTwoStatus[2])
    else $error("word two shows bits outside its range");
  chk_latch_sticky: assert property (
    counterOneStatus[8] |=> counterOneStatus[8])
    else $error("latched flag dropped");
  chk_phasez_drop: assert property (
    $rose(counterOneStatus[3]) |-> ##[1:1000] !counterOneStatus[3])
    else $error("phase Z flag never drops");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_slverr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == fast_counter_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  chk_bvalid_release: assert property (
    $fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response withdrawn");
  chk_rvalid_release: assert property (
    $fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read response withdrawn");

  cover property ($rose(counterOneStatus[8]));
  cover property ($rose(counterOneStatus[3]));
  cover property (s_axi_rvalid && s_axi_rresp == fast_counter_pkg::RESP_SLVERR);
endmodule : status_flags_assertions

bind fast_counter_status_flags status_flags_assertions status_flags_assertions_inst (.clk,
  .arst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .counterOneStatus, .counterTwoStatus);

// File: verif/encoder_source.sv
// Behavioural event source standing in for the encoder side of both counters.
`timescale 1ns/1ps
module encoder_source
(
  input wire logic clk,
  output logic [1:0] sampleStart,
  output logic [1:0] limitHit,
  output logic [1:0] phaseZDone,
  output logic [1:0] latchDone,
  output logic [1:0] offsetDone,
  output logic [1:0] offsetFail,
  output logic [1:0] targetBusy,
  output logic [1:0] rotErr,
  output logic [1:0] rotDone
);
  logic [4:0][1:0] evt = '0;
  logic [5:0] lv = 6'h00;

  assign {offsetDone, latchDone, phaseZDone, limitHit, sampleStart} = evt;
  assign {rotDone, rotErr, targetBusy} = lv;
  initial offsetFail = 2'h0;

  // Fail level is only meaningful with the done pulse, so it flips afterwards.
  task automatic emit(input int e, input logic [1:0] w, input logic [1:0] f);
    @(posedge clk);
    evt[e] <= w;
    offsetFail <= f;
    @(posedge clk);
    evt[e] <= 2'h0;
    offsetFail <= ~f;
  endtask : emit

  task automatic levels(input logic [5:0] v);
    @(posedge clk);
    lv <= v;
  endtask : levels
endmodule : encoder_source

// File: verif/tb_top.sv
// Self-checking bench with bus tasks and a flag model for the status flags block.
`timescale 1ns/1ps
module tb_top;
  localparam int REFRESH = 3;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp;
  logic [31:0] s_axi_rdata, rdVal;
  logic [1:0] sampleStart, limitHit, phaseZDone, latchDone, offsetDone, offsetFail;
  logic [1:0] targetBusy, rotErr, rotDone;
  logic [15:0] counterOneStatus, counterTwoStatus;
  int nErrors = 0;
  int nTests = 0;
  int ctl, lat, lvl, cnt1, cnt2;
  int ovf[2], oerr[2], smp[2];

  always #2.5 clk = ~clk;

  fast_counter_status_flags fast_counter_status_flags_inst (.clk, .arst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sampleStart, .limitHit,
    .phaseZDone, .latchDone, .targetBusy, .rotErr, .rotDone, .offsetDone, .offsetFail,
    .counterOneStatus, .counterTwoStatus);
  encoder_source encoder_source_inst (.clk, .sampleStart, .limitHit, .phaseZDone, .latchDone,
    .offsetDone, .offsetFail, .targetBusy, .rotErr, .rotDone);

  // ----------------------------------------------------------------
  // Model and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] expw(input int k);
    logic [31:0] w;
    int md;
    w = 32'h0;
    md = (ctl >> 4) & 3;
    w[7] = ctl[2*k];
    w[6] = ctl[2*k+1] && smp[k] != 0 && (md == 1 || (md == 2 && k == 0));
    w[1] = ovf[k] != 0;
    w[0] = lvl[k];
    w[4] = lvl[2+k];
    w[5] = lvl[4+k];
    if (k == 0)
    begin
      w[8] = lat != 0;
      w[12] = oerr[0] != 0;
    end
    return w;
  endfunction : expw

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      ad |= s_axi_awready;
      wd |= s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    axr(a);
    check(rdVal, e);
    check(rdResp, r);
  endtask : rdchk

  task automatic setctl(input int c);
    ctl = c;
    for (int k = 0; k < 2; k++)
    begin
      if (!c[2*k]) ovf[k] = 0;
      if (!c[2*k+1]) smp[k] = 0;
    end
    axw(fast_counter_pkg::OFF_CONTROL, c, fast_counter_pkg::RESP_OKAY);
  endtask : setctl

  task automatic fire(input int e, input logic [1:0] w, input logic [1:0] f);
    encoder_source_inst.emit(e, w, f);
    for (int k = 0; k < 2; k++)
    begin
      if (w[k] && e == 0) smp[k] = ctl[2*k+1];
      if (w[k] && e == 1) ovf[k] = ovf[k] | ctl[6+k];
      if (w[k] && e == 3 && k == 0) lat = 1;
      if (w[k] && e == 4) oerr[k] = f[k];
    end
  endtask : fire

  task automatic snap();
    repeat (12) @(posedge clk);
    check({16'h0000, counterOneStatus}, expw(0));
    check({16'h0000, counterTwoStatus}, expw(1));
    rdchk(fast_counter_pkg::OFF_STATUS_ONE, expw(0), fast_counter_pkg::RESP_OKAY);
    rdchk(fast_counter_pkg::OFF_STATUS_TWO, expw(1), fast_counter_pkg::RESP_OKAY);
  endtask : snap

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clk);
    nErrors++;
    close_out();
  end

  initial
  begin
    void'($urandom(32'hbb7c));
    {ctl, lat, lvl} = {32'd0, 32'd0, 32'd0};
    ovf = '{0, 0};
    oerr = '{0, 0};
    smp = '{0, 0};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk(fast_counter_pkg::OFF_STATUS_TWO, 32'h0, fast_counter_pkg::RESP_OKAY);
    rdchk(fast_counter_pkg::OFF_CONTROL, 32'h0, fast_counter_pkg::RESP_OKAY);
    rdchk(fast_counter_pkg::OFF_REFRESH, 32'(fast_counter_pkg::REFRESH_RESET),
      fast_counter_pkg::RESP_OKAY);
    rdchk(8'h10, 32'h0, fast_counter_pkg::RESP_SLVERR);
    axw(fast_counter_pkg::OFF_REFRESH, REFRESH, fast_counter_pkg::RESP_OKAY);
    // The running countdown still holds the reset period, so let it expire once.
    repeat (int'(fast_counter_pkg::REFRESH_RESET) + 1) @(posedge clk);
    setctl(32'h35f);
    snap();
    fire(0, 2'h3, 2'h0);
    fire(1, 2'h3, 2'h0);
    fire(3, 2'h3, 2'h0);
    snap();
    fire(2, 2'h3, 2'h0);
    {cnt1, cnt2} = {32'd0, 32'd0};
    repeat (24)
    begin
      @(posedge clk);
      cnt1 += counterOneStatus[3];
      cnt2 += counterTwoStatus[3];
    end
    check(cnt1, REFRESH + 1);
    check(cnt2, REFRESH + 1);
    for (int i = 0; i < 3; i++)
    begin
      lvl = $urandom & 63;
      encoder_source_inst.levels(6'(lvl));
      fire(4, 2'h3, 2'($urandom));
      snap();
    end
    axw(fast_counter_pkg::OFF_STATUS_ONE, 32'hffff_ffff, fast_counter_pkg::RESP_OKAY);
    axw(8'h10, 32'h0, fast_counter_pkg::RESP_SLVERR);
    snap();
    setctl(32'h36f);
    fire(0, 2'h3, 2'h0);
    snap();
    setctl(32'h34f);
    snap();
    setctl(32'h350);
    snap();
    close_out();
  end
endmodule : tb_top
